//--- mrp_top.sv
// region protection unit: register file, parallel region check, fault result
`timescale 1ns/1ps
// Behaviour
// - type register instruction-region count reads zero
// - type register data-region count reads eight
// - separate-maps bit of type register reads zero
// - enabled, background off: access outside every enabled region, the vector table and control space faults
// - enabled, background on: privileged misses use default map below regions
// - background bit ignored while protection is disabled
// - escalated handlers bypass checking unless escalated enable is set
// - enabled: unprivileged miss faults outside the vector table and control space
// - control space is always execute-never and strongly ordered
// - disabled: every access outside control space gets default map attributes
// - enabled: vector table always permitted, control space permitted except fetches
// - region select holds 0 to 7, choosing base and attribute slot
// - base write, valid clear: update selected region, keep selection
// - base write, valid set: load selection from field, then base
// - base read: valid reads zero, region field shows selection
// - 4 GB region covers all memory, base taken as zero
// - attribute register takes word and halfword writes, fixed field layout
// - execute-never blocks fetches from the region
// - each subregion-disable bit removes one eighth of a region of 256 bytes or more
// - size field gives 2^(size+1) bytes, smallest 32 bytes; the code also decodes size fields below 4 into smaller regions
// - disabled subregion lets lower region match, else privileged access with background on gets default map, else fault
module mrp_top #(
  parameter int NREG = 8,
  parameter logic [31:0] VT_BASE = 32'h00000000,
  parameter logic [31:0] VT_SIZE = 32'h00000400
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_addr,
  input wire logic [3:0] reg_be,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata_q,
  // core access check
  input wire logic acc_valid,
  input wire mrp_pkg::mrp_req_s acc_req,
  output logic acc_done_q,
  output logic acc_permit_q,
  output logic acc_fault_q,
  output mrp_pkg::mrp_attr_s acc_attr_q
);
  import mrp_pkg::*;

  // ==========================================================
  // elaboration checks
  if (NREG < 1 || NREG > 8) begin : g_bad_nreg
    $error("NREG must lie between 1 and 8");
  end

  // ==========================================================
  // byte enables to bit mask
  function automatic logic [31:0] be_bits(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // ==========================================================
  // state
  logic [2:0] ctrl_q;
  logic [2:0] sel_q;
  logic [26:0] base_q [NREG];
  logic [31:0] attr_q [NREG];

  // ==========================================================
  // register decode
  logic hit_type, hit_ctrl, hit_sel, hit_base, hit_attr;
  logic wr_ctrl, wr_sel, wr_base, wr_attr;
  logic base_valid;
  logic [2:0] wr_slot;
  logic [31:0] attr_wmask;

  assign hit_type = reg_addr == MRP_TYPE_OFS;
  assign hit_ctrl = reg_addr == MRP_CTRL_OFS;
  assign hit_sel = reg_addr == MRP_SEL_OFS;
  assign hit_base = reg_addr == MRP_BASE_OFS;
  assign hit_attr = reg_addr == MRP_ATTR_OFS;
  // word-only registers ignore partial writes
  assign wr_ctrl = ce && reg_wr && hit_ctrl && (reg_be == 4'hF);
  assign wr_sel = ce && reg_wr && hit_sel && (reg_be == 4'hF);
  assign wr_base = ce && reg_wr && hit_base && (reg_be == 4'hF);
  assign wr_attr = ce && reg_wr && hit_attr;
  assign base_valid = reg_wdata[MRP_VALID_POS];
  // valid set retargets both the selection and the base write
  assign wr_slot = base_valid ? reg_wdata[2:0] : sel_q;
  assign attr_wmask = be_bits(reg_be) & MRP_ATTR_MASK;

  // ==========================================================
  // read mux
  logic [31:0] type_word, ctrl_word, sel_word, base_word, attr_word, rd_word;

  assign type_word = (32'(MRP_INSTR_CNT_VAL) << MRP_INSTR_CNT_POS)
    | (32'(MRP_DATA_CNT_VAL) << MRP_DATA_CNT_POS)
    | (32'h0 << MRP_SEPARATE_POS);
  assign ctrl_word = {29'h0, ctrl_q};
  assign sel_word = {29'h0, sel_q};
  assign base_word = {base_q[sel_q], 5'h00};
  assign attr_word = attr_q[sel_q];
  assign rd_word = hit_type ? type_word :
                   hit_ctrl ? ctrl_word :
                   hit_sel ? sel_word :
                   hit_base ? (base_word | sel_word) :
                   hit_attr ? attr_word : 32'h00000000;

  // ==========================================================
  // control, select and read data registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_q <= MRP_CTRL_RST;
      sel_q <= 3'h0;
      reg_rdata_q <= 32'h00000000;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata[2:0];
      end
      if (wr_sel) begin
        sel_q <= reg_wdata[2:0];
      end else if (wr_base && base_valid) begin
        sel_q <= reg_wdata[2:0];
      end
      reg_rdata_q <= reg_rd ? rd_word : 32'h00000000;
    end
  end

  // ==========================================================
  // region storage, one slot per region
  for (genvar g = 0; g < NREG; g++) begin : g_slot
    always_ff @(posedge clk) begin
      if (!nrst) begin
        base_q[g] <= MRP_BASE_RST;
        attr_q[g] <= MRP_ATTR_RST;
      end else begin
        if (wr_base && wr_slot == 3'(g)) begin
          base_q[g] <= reg_wdata[31:MRP_BASE_LSB];
        end
        if (wr_attr && sel_q == 3'(g)) begin
          attr_q[g] <= (attr_q[g] & ~attr_wmask) | (reg_wdata & attr_wmask);
        end
      end
    end
  end

  // ==========================================================
  // parallel region compare
  logic [NREG-1:0] hits;

  for (genvar g = 0; g < NREG; g++) begin : g_match
    mrp_region_match u_match (
      .base(base_q[g]),
      .attr(attr_q[g]),
      .addr(acc_req.addr),
      .hit(hits[g])
    );
  end

  // highest-numbered hit wins
  logic any_hit;
  logic [2:0] win;

  always_comb begin
    any_hit = 1'b0;
    win = 3'h0;
    for (int i = 0; i < NREG; i++) begin
      if (hits[i]) begin
        any_hit = 1'b1;
        win = 3'(i);
      end
    end
  end

  // ==========================================================
  // decision
  logic en, esc_en, bg_en, active, in_scs, in_vt, is_fetch, reg_no_exec, bg_ok;
  logic permit_d;
  mrp_attr_s reg_attr, attr_d;
  logic [31:0] win_attr;

  assign en = ctrl_q[MRP_CTRL_EN_POS];
  assign esc_en = ctrl_q[MRP_CTRL_ESC_POS];
  assign bg_en = ctrl_q[MRP_CTRL_BG_POS];
  // escalated handlers run unchecked unless asked for
  assign active = en && !(acc_req.escal && !esc_en);
  assign in_scs = mrp_in_win(acc_req.addr, MRP_SCS_BASE, MRP_SCS_SIZE);
  assign in_vt = mrp_in_win(acc_req.addr, VT_BASE, VT_SIZE);
  assign is_fetch = acc_req.kind == MRP_FETCH;
  assign win_attr = attr_q[win];
  assign reg_no_exec = win_attr[MRP_EXEC_NEVER_POS];
  // strongly ordered only when type extension, cacheable and bufferable are all zero
  assign reg_attr = '{exec_never: reg_no_exec, perm: win_attr[MRP_PERM_LSB +: 3],
                      type_ext: win_attr[MRP_TYPE_EXT_LSB +: 3], s: win_attr[MRP_S_POS],
                      c: win_attr[MRP_C_POS], b: win_attr[MRP_B_POS],
                      so: win_attr[MRP_TYPE_EXT_LSB +: 3] == 3'h0 && !win_attr[MRP_C_POS] && !win_attr[MRP_B_POS]};
  // background only for privileged code, and only when enabled
  assign bg_ok = bg_en && acc_req.priv;

  always_comb begin
    permit_d = 1'b1;
    attr_d = MRP_DEF_ATTR;
    if (in_scs) begin
      attr_d = MRP_SCS_ATTR;
      permit_d = !is_fetch;
    end else if (!active) begin
      attr_d = MRP_DEF_ATTR;
    end else if (in_vt) begin
      permit_d = 1'b1;
    end else if (any_hit) begin
      attr_d = reg_attr;
      permit_d = !(is_fetch && reg_no_exec);
    end else if (bg_ok) begin
      attr_d = MRP_DEF_ATTR;
    end else begin
      permit_d = 1'b0;
    end
  end

  // ==========================================================
  // registered result, one cycle after the request
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc_done_q <= 1'b0;
      acc_permit_q <= 1'b0;
      acc_fault_q <= 1'b0;
      acc_attr_q <= MRP_DEF_ATTR;
    end else if (ce) begin
      acc_done_q <= acc_valid;
      acc_permit_q <= acc_valid && permit_d;
      acc_fault_q <= acc_valid && !permit_d;
      if (acc_valid) begin
        acc_attr_q <= attr_d;
      end
    end
  end

  // ==========================================================
  // assertions
  instr_count_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_rd && hit_type |=> reg_rdata_q[23:16] == 8'h00)
    else $error("instruction region count not zero");
  data_count_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_rd && hit_type |=> reg_rdata_q[15:8] == 8'h08)
    else $error("data region count not eight");
  separate_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_rd && hit_type |=> !reg_rdata_q[0])
    else $error("separate map bit set");
  sel_keep_a: assert property (@(posedge clk) disable iff (!nrst)
    wr_base && !base_valid && !wr_sel |=> sel_q == $past(sel_q))
    else $error("selection moved on base write");
  sel_load_a: assert property (@(posedge clk) disable iff (!nrst)
    wr_base && base_valid |=> sel_q == $past(reg_wdata[2:0]) && base_q[sel_q] == $past(reg_wdata[31:5]))
    else $error("valid base write did not retarget");
  base_read_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_rd && hit_base && !wr_sel && !wr_base |=> !reg_rdata_q[4] && reg_rdata_q[2:0] == sel_q)
    else $error("base read shows wrong selection");
  disabled_pass_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && acc_valid && !en && !in_scs |=> acc_permit_q && acc_attr_q == MRP_DEF_ATTR)
    else $error("disabled unit refused access");
  unpriv_miss_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && acc_valid && active && !acc_req.priv && !any_hit && !in_scs && !in_vt |=> acc_fault_q)
    else $error("unprivileged miss not faulted");
  scs_fetch_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && acc_valid && in_scs && is_fetch |=> acc_fault_q && acc_attr_q.so)
    else $error("control space fetch allowed");
  never_fetch_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && acc_valid && active && !in_scs && !in_vt && any_hit && reg_no_exec && is_fetch |=> acc_fault_q)
    else $error("execute-never fetch allowed");
  escal_bypass_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && acc_valid && acc_req.escal && !esc_en && !in_scs |=> acc_permit_q)
    else $error("escalated handler was checked");
  result_once_a: assert property (@(posedge clk) disable iff (!nrst)
    acc_done_q |-> acc_permit_q != acc_fault_q)
    else $error("result not exactly one of permit and fault");
  sel_load_word_a: assert property (@(posedge clk) disable iff (!nrst)
    wr_sel |=> sel_q == $past(reg_wdata[2:0]))
    else $error("region select not loaded");
  bg_priv_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && acc_valid && active && bg_ok && !any_hit && !in_scs |=> acc_permit_q && acc_attr_q == MRP_DEF_ATTR)
    else $error("privileged miss not given default map");
  scs_order_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && acc_valid && in_scs |=> acc_attr_q.exec_never && acc_attr_q.so)
    else $error("control space not execute-never and ordered");
  vt_permit_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && acc_valid && active && in_vt |=> acc_permit_q)
    else $error("vector table access refused");
  // a frozen cycle must neither answer a request nor take a write
  freeze_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !ce |=> acc_done_q == $past(acc_done_q) && ctrl_q == $past(ctrl_q) && reg_rdata_q == $past(reg_rdata_q))
    else $error("state moved while clock enable low");

  cov_fault_c: cover property (@(posedge clk) disable iff (!nrst) acc_fault_q);
  cov_bg_c: cover property (@(posedge clk) disable iff (!nrst) ce && acc_valid && active && !any_hit && bg_ok);
  cov_overlap_c: cover property (@(posedge clk) disable iff (!nrst) ce && acc_valid && $countones(hits) > 1);
  cov_half_c: cover property (@(posedge clk) disable iff (!nrst) wr_attr && reg_be == 4'h3);
  cov_freeze_c: cover property (@(posedge clk) disable iff (!nrst) !ce && acc_valid);
endmodule

//--- mrp_pkg.sv
// package: register map, field layout and types of the region protection unit
package mrp_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [31:0] MRP_TYPE_OFS = 32'hE000ED90;
  localparam logic [31:0] MRP_CTRL_OFS = 32'hE000ED94;
  localparam logic [31:0] MRP_SEL_OFS = 32'hE000ED98;
  localparam logic [31:0] MRP_BASE_OFS = 32'hE000ED9C;
  localparam logic [31:0] MRP_ATTR_OFS = 32'hE000EDA0;

  // ==========================================================
  // type register fields
  localparam logic [7:0] MRP_INSTR_CNT_VAL = 8'h00;
  localparam logic [7:0] MRP_DATA_CNT_VAL = 8'h08;
  localparam int MRP_INSTR_CNT_POS = 16;
  localparam int MRP_DATA_CNT_POS = 8;
  localparam int MRP_SEPARATE_POS = 0;

  // control register fields and reset
  localparam int MRP_CTRL_EN_POS = 0;
  localparam int MRP_CTRL_ESC_POS = 1;
  localparam int MRP_CTRL_BG_POS = 2;
  localparam logic [2:0] MRP_CTRL_RST = 3'h0;

  // base register fields
  localparam int MRP_VALID_POS = 4;
  localparam int MRP_BASE_LSB = 5;
  localparam logic [26:0] MRP_BASE_RST = 27'h0;

  // attribute/size register fields, writable mask and reset
  localparam int MRP_EXEC_NEVER_POS = 28;
  localparam int MRP_PERM_LSB = 24;
  localparam int MRP_TYPE_EXT_LSB = 19;
  localparam int MRP_S_POS = 18;
  localparam int MRP_C_POS = 17;
  localparam int MRP_B_POS = 16;
  localparam int MRP_SUB_DIS_LSB = 8;
  localparam int MRP_SIZE_LSB = 1;
  localparam int MRP_REN_POS = 0;
  localparam logic [31:0] MRP_ATTR_MASK = 32'h173FFF3F;
  localparam logic [31:0] MRP_ATTR_RST = 32'h00000000;

  // ==========================================================
  // fixed windows of the memory map
  localparam logic [31:0] MRP_SCS_BASE = 32'hE000E000;
  localparam logic [31:0] MRP_SCS_SIZE = 32'h00001000;

  // kind of core access
  typedef enum logic [1:0] {
    MRP_FETCH = 2'b00,
    MRP_READ = 2'b01,
    MRP_WRITE = 2'b10
  } mrp_kind_e;

  // one access request from the core
  typedef struct packed {
    logic [31:0] addr;
    logic priv;
    logic escal;
    mrp_kind_e kind;
  } mrp_req_s;

  // memory attributes returned with a result
  typedef struct packed {
    logic exec_never;
    logic [2:0] perm;
    logic [2:0] type_ext;
    logic s;
    logic c;
    logic b;
    logic so;
  } mrp_attr_s;

  // default map: normal memory, fetch allowed
  localparam mrp_attr_s MRP_DEF_ATTR = '{exec_never: 1'b0, perm: 3'h3, type_ext: 3'h0,
                                         s: 1'b0, c: 1'b1, b: 1'b0, so: 1'b0};
  // control space: execute-never and strongly ordered
  localparam mrp_attr_s MRP_SCS_ATTR = '{exec_never: 1'b1, perm: 3'h1, type_ext: 3'h0,
                                         s: 1'b1, c: 1'b0, b: 1'b0, so: 1'b1};

  // ==========================================================
  // address inside [base, base+size)
  function automatic logic mrp_in_win(input logic [31:0] a, input logic [31:0] base, input logic [31:0] size);
    logic [31:0] off;
    off = a - base;
    return (a >= base) && (off < size);
  endfunction

endpackage

//--- mrp_region_match.sv
// one region: address and subregion match against base and attribute word
`timescale 1ns/1ps
module mrp_region_match (
  // region setup
  input wire logic [26:0] base,
  input wire logic [31:0] attr,
  // address under test
  input wire logic [31:0] addr,
  output logic hit
);
  import mrp_pkg::*;

  // ==========================================================
  // size decode: region covers 2^(size+1) bytes
  logic [4:0] size_f;
  logic [5:0] nbits;
  logic [32:0] low_mask;
  logic [31:0] hi_mask;
  logic [31:0] base_full;
  logic base_ok;
  logic [31:0] sub_shift;
  logic [2:0] sub_idx;
  logic sub_on;

  assign size_f = attr[MRP_SIZE_LSB +: 5];
  assign nbits = 6'(size_f) + 6'h01;
  // 4 GB leaves an all-zero high mask, so the base is never used
  assign low_mask = (33'h1 << nbits) - 33'h1;
  assign hi_mask = ~low_mask[31:0];
  assign base_full = {base, 5'h00};
  assign base_ok = ((addr ^ base_full) & hi_mask) == 32'h00000000;

  // subregion index is the top three bits below the region boundary
  assign sub_shift = addr >> (nbits - 6'h03);
  assign sub_idx = (nbits >= 6'h08) ? sub_shift[2:0] : 3'h0;
  // small regions carry no subregions; their disable bits are expected zero
  assign sub_on = ~attr[MRP_SUB_DIS_LSB + 32'(sub_idx)];

  assign hit = attr[MRP_REN_POS] && base_ok && sub_on;
endmodule

//--- mrp_core_model.sv
// core-side model: launches one access per command pulse, scrambles idle request lines
`timescale 1ns/1ps
module mrp_core_model
  import mrp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // command from the bench
  input wire logic go,
  input wire mrp_pkg::mrp_req_s req_in,
  // access port towards the unit
  output logic acc_valid,
  output mrp_pkg::mrp_req_s acc_req
);
  // ==========================================================
  // launch; idle lines are inverted each cycle so a stale request never looks valid
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc_valid <= 1'b0;
      acc_req <= '0;
    end else begin
      acc_valid <= go;
      acc_req <= go ? req_in : ~acc_req;
    end
  end
endmodule

//--- memory_region_protection_unit_test.sv
// self-checking bench of the region protection unit with a core-side model
`timescale 1ns/1ps
module memory_region_protection_unit_test;
  import mrp_pkg::*;
  // ==========================================================
  // stimulus, observed outputs and bench state
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [3:0] reg_be = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic ce = 1'b1;
  logic go = 1'b0;
  mrp_req_s req_in = '0;
  mrp_req_s acc_req;
  mrp_attr_s acc_attr_q;
  logic acc_valid, acc_done_q, acc_permit_q, acc_fault_q;
  logic [31:0] reg_rdata_q;
  int miscompares = 0;
  int samples_checked = 0;
  int seed = 76;
  logic [31:0] d;
  logic [4:0] n;
  // shadow of what software has programmed
  logic [2:0] sh_ctrl = 3'h0;
  logic [2:0] sh_sel = 3'h0;
  logic [26:0] sh_base [8];
  logic [31:0] sh_attr [8];

  // 125 MHz clock
  always #4 clk = ~clk;

  // ==========================================================
  // unit and core model; ce drops once to show that requests are frozen out
  mrp_top dut_u (.clk(clk), .nrst(nrst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .acc_valid(acc_valid),
    .acc_req(acc_req), .acc_done_q(acc_done_q), .acc_permit_q(acc_permit_q), .acc_fault_q(acc_fault_q),
    .acc_attr_q(acc_attr_q));
  mrp_core_model core_u (.clk(clk), .nrst(nrst), .go(go), .req_in(req_in), .acc_valid(acc_valid),
    .acc_req(acc_req));

  // ==========================================================
  // checking and closing
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // expected register contents from the shadow
  function automatic logic [31:0] exp_reg(input logic [31:0] a);
    case (a)
      MRP_TYPE_OFS: return {8'h00, MRP_INSTR_CNT_VAL, MRP_DATA_CNT_VAL, 8'h00};
      MRP_CTRL_OFS: return {29'h0, sh_ctrl};
      MRP_SEL_OFS: return {29'h0, sh_sel};
      MRP_BASE_OFS: return {sh_base[sh_sel], 2'h0, sh_sel};
      MRP_ATTR_OFS: return sh_attr[sh_sel];
      default: return 32'h0;
    endcase
  endfunction

  // region match: size 2^(n+1), a 4 GB region masks every address bit away
  function automatic logic hit(input int r, input logic [31:0] a);
    logic [4:0] sz;
    logic [31:0] m;
    logic h;
    sz = sh_attr[r][5:1];
    m = ~((32'h2 << sz) - 32'h1);
    h = sh_attr[r][0] && ((a & m) == ({sh_base[r], 5'h0} & m));
    if (sz >= 5'h7) begin
      h = h && !sh_attr[r][8 + ((a >> (sz - 5'h2)) & 32'h7)];
    end
    return h;
  endfunction

  // expected {attributes defined, permit, attributes}
  function automatic logic [12:0] exp_acc(input mrp_req_s q);
    logic [31:0] w;
    int top;
    top = -1;
    for (int r = 0; r < 8; r++) begin
      if (hit(r, q.addr)) top = r;
    end
    if (q.addr[31:12] == 20'hE000E) return {1'b1, q.kind != MRP_FETCH, MRP_SCS_ATTR};
    if (!sh_ctrl[0] || (q.escal && !sh_ctrl[1])) return {2'h3, MRP_DEF_ATTR};
    if (q.addr < 32'h400) return {2'h1, MRP_DEF_ATTR};
    if (top >= 0) begin
      w = sh_attr[top];
      return {1'b1, !(w[28] && q.kind == MRP_FETCH), w[28], w[26:24], w[21:19], w[18:16],
        w[21:19] == 3'h0 && w[17:16] == 2'h0};
    end
    if (q.priv && sh_ctrl[2]) return {2'h3, MRP_DEF_ATTR};
    return {2'h0, MRP_DEF_ATTR};
  endfunction

  // ==========================================================
  // register port cycles; shadow follows the refusals of partial writes
  task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] be);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    reg_be <= be;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (be == 4'hF && a == MRP_CTRL_OFS) sh_ctrl = v[2:0];
    if (be == 4'hF && (a == MRP_SEL_OFS || (a == MRP_BASE_OFS && v[4]))) sh_sel = v[2:0];
    if (be == 4'hF && a == MRP_BASE_OFS) sh_base[sh_sel] = v[31:5];
    for (int b = 0; b < 4; b++) begin
      if (a == MRP_ATTR_OFS && be[b]) sh_attr[sh_sel][8*b+:8] = v[8*b+:8] & MRP_ATTR_MASK[8*b+:8];
    end
  endtask

  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata_q, exp_reg(a), "register read");
  endtask

  task automatic setreg(input int r, input logic [31:0] b, input logic [31:0] at);
    wr(MRP_BASE_OFS, b | 32'h10 | 32'(r), 4'hF);
    wr(MRP_ATTR_OFS, at, 4'hF);
  endtask

  // one access through the core model, result one cycle after it is taken
  task automatic acc(input logic [31:0] a, input logic p, input logic e, input logic [1:0] k);
    mrp_req_s q;
    logic [12:0] x;
    q = '{addr: a, priv: p, escal: e, kind: mrp_kind_e'(k)};
    @(posedge clk);
    go <= 1'b1;
    req_in <= q;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    x = exp_acc(q);
    check({29'h0, acc_done_q, acc_permit_q, acc_fault_q}, {29'h0, 1'b1, x[11], !x[11]}, "access result");
    if (x[12]) check({21'h0, acc_attr_q}, {21'h0, x[10:0]}, "access attributes");
  endtask

  // ==========================================================
  // hang guard
  initial begin
    #600000;
    miscompares++;
    test_done();
  end

  // main sequence
  initial begin
    foreach (sh_base[i]) begin
      sh_base[i] = 27'h0;
      sh_attr[i] = 32'h0;
    end
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) rd(MRP_TYPE_OFS + 32'(4 * i));
    wr(MRP_TYPE_OFS, 32'hFFFFFFFF, 4'hF);
    rd(MRP_TYPE_OFS);
    wr(MRP_SEL_OFS, 32'h3, 4'hF);
    wr(MRP_BASE_OFS, 32'h20000005, 4'hF);
    rd(MRP_SEL_OFS);
    rd(MRP_BASE_OFS);
    wr(MRP_BASE_OFS, 32'h30000016, 4'hF);
    rd(MRP_SEL_OFS);
    rd(MRP_BASE_OFS);
    wr(MRP_ATTR_OFS, 32'hFFFFFFFF, 4'hC);
    rd(MRP_ATTR_OFS);
    wr(MRP_ATTR_OFS, 32'hFFFFFFFF, 4'h3);
    rd(MRP_ATTR_OFS);
    wr(MRP_CTRL_OFS, 32'h7, 4'h3);
    rd(MRP_CTRL_OFS);
    // clock enable low: a control write and an access must both be frozen out
    @(posedge clk);
    ce <= 1'b0;
    reg_wr <= 1'b1;
    reg_addr <= MRP_CTRL_OFS;
    reg_wdata <= 32'h00000001;
    reg_be <= 4'hF;
    go <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    go <= 1'b0;
    @(posedge clk);
    ce <= 1'b1;
    #1;
    check({31'h0, acc_done_q}, 32'h0, "frozen access answered");
    rd(MRP_CTRL_OFS);
    // unit off with background bit set: default map, control space still guarded
    wr(MRP_CTRL_OFS, 32'h4, 4'hF);
    for (int k = 0; k < 3; k++) begin
      acc(32'h30000020, 1'b0, 1'b0, 2'(k));
      acc(32'hE000E010, 1'b1, 1'b0, 2'(k));
    end
    // random region sets, aligned bases and no subregion bits on small regions
    repeat (30) begin
      for (int r = 0; r < 8; r++) begin
        n = 5'(4 + ($unsigned($random(seed)) % 11));
        d = $random(seed) & 32'h1FFFFFFF & ~((32'h2 << n) - 32'h1);
        setreg(r, d, 32'h0);
        d = $random(seed);
        if (n < 5'h7) d[15:8] = 8'h00;
        d[5:1] = n;
        wr(MRP_ATTR_OFS, d, r[0] ? 4'hF : 4'h3);
      end
      d = $random(seed);
      if (!d[0]) d[1] = 1'b0;
      wr(MRP_CTRL_OFS, d, 4'hF);
      repeat (16) begin
        d = $random(seed);
        acc({sh_base[d[6:4]], 5'h0} + (d & 32'h00007F00), d[0], d[1], 2'(d[3:2] % 3));
      end
    end
    // corners: 4 GB execute-never region under a region with dead subregions
    for (int r = 2; r < 8; r++) setreg(r, 32'h0, 32'h0);
    setreg(0, 32'h0, 32'h1000003F);
    setreg(1, 32'h20000000, 32'h0306031F);
    wr(MRP_CTRL_OFS, 32'h1, 4'hF);
    acc(32'h20000010, 1'b0, 1'b0, 2'h1);
    acc(32'h20004000, 1'b0, 1'b0, 2'h0);
    acc(32'h50000000, 1'b1, 1'b0, 2'h0);
    acc(32'h50000000, 1'b1, 1'b1, 2'h0);
    acc(32'hE000E020, 1'b0, 1'b0, 2'h0);
    acc(32'hE000E020, 1'b0, 1'b0, 2'h2);
    acc(32'h00000100, 1'b0, 1'b0, 2'h0);
    setreg(0, 32'h0, 32'h0);
    wr(MRP_CTRL_OFS, 32'h5, 4'hF);
    acc(32'h60000000, 1'b1, 1'b0, 2'h1);
    acc(32'h60000000, 1'b0, 1'b0, 2'h1);
    wr(MRP_CTRL_OFS, 32'h3, 4'hF);
    acc(32'h60000000, 1'b1, 1'b1, 2'h2);
    acc(32'h60000000, 1'b1, 1'b0, 2'h1);
    test_done();
  end
endmodule
